// >>> include/tid_defs.vh
// Purpose: constants for the test-port instruction decoder
// Assumes: three-bit instructions, codes written MSB first
// Notes:   state codes follow the usual sixteen-state test controller
// Operation
// - Codes are binary, most significant bit first
// - Code 000 selects boundary scan path
// - Code 001 loads and selects identification register
// - Code 010 captures ring, boundary path, floats outputs
// - Reserved codes 011, 110 act as bypass
// - Code 100 captures ring, boundary path only
// - Code 111 selects one-bit bypass register
// - Identification instruction after power-up and reset state
// - Three-bit instruction loaded only in Shift-IR
// - Capture-IR loads low bits with 01
// - New instruction effective only at Update-IR
// - Identification register 32 bits, bit 0 first
`ifndef TID_DEFS_VH
`define TID_DEFS_VH
// ==========================================================
// Instruction codes
`define TID_IR_W          3
`define TID_OP_EXTEST     3'h0
`define TID_OP_IDCODE     3'h1
`define TID_OP_SAMPLEZ    3'h2
`define TID_OP_RSVD_A     3'h3
`define TID_OP_SAMPLE     3'h4
`define TID_OP_PRIVATE    3'h5
`define TID_OP_RSVD_B     3'h6
`define TID_OP_BYPASS     3'h7
`define TID_IR_CAPTURE    3'h1
// ==========================================================
// Path selections
`define TID_SEL_BYP       2'h0
`define TID_SEL_BSR       2'h1
`define TID_SEL_IDR       2'h2
// ==========================================================
// Test controller states
`define TID_ST_RESET      4'h0
`define TID_ST_IDLE       4'h1
`define TID_ST_SEL_DR     4'h2
`define TID_ST_CAP_DR     4'h3
`define TID_ST_SH_DR      4'h4
`define TID_ST_EX1_DR     4'h5
`define TID_ST_PAU_DR     4'h6
`define TID_ST_EX2_DR     4'h7
`define TID_ST_UPD_DR     4'h8
`define TID_ST_SEL_IR     4'h9
`define TID_ST_CAP_IR     4'ha
`define TID_ST_SH_IR      4'hb
`define TID_ST_EX1_IR     4'hc
`define TID_ST_PAU_IR     4'hd
`define TID_ST_EX2_IR     4'he
`define TID_ST_UPD_IR     4'hf
// ==========================================================
// Identification value, arbitrary neutral value, bit 0 set
`define TID_IDCODE_VAL    32'h1234_5679
`define TID_ID_W          32
`endif

// >>> rtl/tid_sync.v
// Purpose: two-stage synchroniser for one pin level
// Assumes: input asynchronous to clk
// Notes:   first stage read only by the second
`timescale 1ns/1ps
module tid_sync (
   input  wire clk,
   input  wire rstn,
   input  wire din,
   output reg  dout
);
   reg meta_q;
   // ==========================================================
   // Two flops, only the second looks at the first one
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         meta_q <= 1'b0;
         dout   <= 1'b0;
      end else begin
         meta_q <= din;
         dout   <= meta_q;
      end
   end
endmodule // tid_sync

// >>> rtl/tid_decoder.v
// Purpose: test-port instruction register, decode and serial paths
// Assumes: tck, tms, tdi, trst_n from pins; tck much slower than clk
// Notes:   boundary cells live outside; this block steers and strobes them
`timescale 1ns/1ps
`include "tid_defs.vh"
module tid_decoder #(
   parameter ID_VALUE = `TID_IDCODE_VAL
) (
   input  wire        clk,
   input  wire        rstn,
   input  wire        tck,
   input  wire        tms,
   input  wire        tdi,
   input  wire        trst_n,
   input  wire        bsr_tdo,
   output reg         tdo_q,
   output reg         tdo_oe_n_q,
   output reg         bsr_capture_q,
   output reg         bsr_shift_q,
   output reg         bsr_update_q,
   output reg         bsr_sel_q,
   output reg         extest_q,
   output reg         outputs_hiz_q,
   output reg  [2:0]  instr_q
);
   // Synchronised pin levels
   wire       tck_s;
   wire       tms_s;
   wire       tdi_s;
   wire       trst_s;
   wire       bsr_s;
   // Controller and data register state
   reg        tck_d1_q;
   reg  [3:0] state_q;
   reg  [3:0] state_d;
   reg  [`TID_IR_W-1:0] ir_sh_q;
   reg  [`TID_ID_W-1:0] id_sh_q;
   reg        byp_q;
   // Decoded path and data-register phase
   reg  [1:0] sel;
   reg        cap_dr;
   reg        sh_dr;

   // ==========================================================
   // Pin synchronisers
   // Every pin is asynchronous to clk; two flops each, so a level caught
   // mid-transition never reaches the controller decode
   localparam NPIN = 5;
   wire [NPIN-1:0] pin_in;
   wire [NPIN-1:0] pin_out;
   assign pin_in = {bsr_tdo, trst_n, tdi, tms, tck};
   genvar gi;
   generate
      for (gi = 0; gi < NPIN; gi = gi + 1) begin : g_sync
         tid_sync u_sync (
            .clk  (clk),
            .rstn (rstn),
            .din  (pin_in[gi]),
            .dout (pin_out[gi])
         );
      end
   endgenerate
   // Split the synchronised bus back into named levels
   assign tck_s  = pin_out[0];
   assign tms_s  = pin_out[1];
   assign tdi_s  = pin_out[2];
   assign trst_s = pin_out[3];
   assign bsr_s  = pin_out[4];

   // Edge finders on synced tck; the delay flop resets to the idle low
   // level, so the release of reset never shows a false edge
   wire tck_rise = tck_s & ~tck_d1_q;
   wire tck_fall = ~tck_s & tck_d1_q;

   // ==========================================================
   // Decode of an instruction to its serial path
   // Reserved and private codes fall to bypass so the chain stays one bit
   function [1:0] path_of;
      input [2:0] op;
      begin
         case (op)
            `TID_OP_EXTEST:  path_of = `TID_SEL_BSR;
            `TID_OP_IDCODE:  path_of = `TID_SEL_IDR;
            `TID_OP_SAMPLEZ: path_of = `TID_SEL_BSR;
            `TID_OP_SAMPLE:  path_of = `TID_SEL_BSR;
            `TID_OP_RSVD_A:  path_of = `TID_SEL_BYP;
            `TID_OP_RSVD_B:  path_of = `TID_SEL_BYP;
            `TID_OP_PRIVATE: path_of = `TID_SEL_BYP;
            default:         path_of = `TID_SEL_BYP;
         endcase
      end
   endfunction

   // ==========================================================
   // Controller next state on tms
   // Standard sixteen-state walk; tms only matters at a rising tck
   always @* begin
      case (state_q)
         `TID_ST_RESET:  state_d = tms_s ? `TID_ST_RESET  : `TID_ST_IDLE;
         `TID_ST_IDLE:   state_d = tms_s ? `TID_ST_SEL_DR : `TID_ST_IDLE;
         `TID_ST_SEL_DR: state_d = tms_s ? `TID_ST_SEL_IR : `TID_ST_CAP_DR;
         `TID_ST_CAP_DR: state_d = tms_s ? `TID_ST_EX1_DR : `TID_ST_SH_DR;
         `TID_ST_SH_DR:  state_d = tms_s ? `TID_ST_EX1_DR : `TID_ST_SH_DR;
         `TID_ST_EX1_DR: state_d = tms_s ? `TID_ST_UPD_DR : `TID_ST_PAU_DR;
         `TID_ST_PAU_DR: state_d = tms_s ? `TID_ST_EX2_DR : `TID_ST_PAU_DR;
         `TID_ST_EX2_DR: state_d = tms_s ? `TID_ST_UPD_DR : `TID_ST_SH_DR;
         `TID_ST_UPD_DR: state_d = tms_s ? `TID_ST_SEL_DR : `TID_ST_IDLE;
         `TID_ST_SEL_IR: state_d = tms_s ? `TID_ST_RESET  : `TID_ST_CAP_IR;
         `TID_ST_CAP_IR: state_d = tms_s ? `TID_ST_EX1_IR : `TID_ST_SH_IR;
         `TID_ST_SH_IR:  state_d = tms_s ? `TID_ST_EX1_IR : `TID_ST_SH_IR;
         `TID_ST_EX1_IR: state_d = tms_s ? `TID_ST_UPD_IR : `TID_ST_PAU_IR;
         `TID_ST_PAU_IR: state_d = tms_s ? `TID_ST_EX2_IR : `TID_ST_PAU_IR;
         `TID_ST_EX2_IR: state_d = tms_s ? `TID_ST_UPD_IR : `TID_ST_SH_IR;
         `TID_ST_UPD_IR: state_d = tms_s ? `TID_ST_SEL_DR : `TID_ST_IDLE;
         default:        state_d = `TID_ST_RESET;
      endcase
   end

   // Selected path and data-register phase, from the active instruction
   always @* begin
      sel    = path_of(instr_q);
      cap_dr = (state_q == `TID_ST_CAP_DR);
      sh_dr  = (state_q == `TID_ST_SH_DR);
   end

   // ==========================================================
   // Controller, instruction and data registers on tck edges
   // Edge delay flop and controller state
   // The test reset pin wins over any tck edge in the same clk
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tck_d1_q <= 1'b0;
         state_q  <= `TID_ST_RESET;
      end else begin
         tck_d1_q <= tck_s;
         if (!trst_s)
            state_q <= `TID_ST_RESET;
         else if (tck_rise)
            state_q <= state_d;
      end
   end

   // Active instruction: default on every reset path, new code at Update-IR
   // Loading on the edge that enters the reset state keeps the default
   // active for the whole time the controller sits there
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         instr_q <= `TID_OP_IDCODE;
      end else if (!trst_s) begin
         instr_q <= `TID_OP_IDCODE;
      end else if (tck_rise && state_d == `TID_ST_RESET) begin
         instr_q <= `TID_OP_IDCODE;
      end else if (tck_fall && state_q == `TID_ST_UPD_IR) begin
         instr_q <= ir_sh_q;
      end
   end

   // Instruction shift register, live only in Capture-IR and Shift-IR
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ir_sh_q <= `TID_IR_CAPTURE;
      end else if (trst_s && tck_rise) begin
         if (state_q == `TID_ST_CAP_IR)
            ir_sh_q <= `TID_IR_CAPTURE;
         else if (state_q == `TID_ST_SH_IR)
            ir_sh_q <= {tdi_s, ir_sh_q[`TID_IR_W-1:1]};
      end
   end

   // Identification and bypass data registers
   // Both load at Capture-DR so a stale value never leads the chain
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         id_sh_q <= {`TID_ID_W{1'b0}};
         byp_q   <= 1'b0;
      end else if (trst_s && tck_rise) begin
         if (cap_dr && sel == `TID_SEL_IDR)
            id_sh_q <= ID_VALUE;
         else if (sh_dr && sel == `TID_SEL_IDR)
            id_sh_q <= {tdi_s, id_sh_q[`TID_ID_W-1:1]};
         if (cap_dr)
            byp_q <= 1'b0;
         else if (sh_dr)
            byp_q <= tdi_s;
      end
   end

   // ==========================================================
   // Serial output and update strobe change on falling tck; capture and shift strobes on rising tck
   // Strobes are one clk pulse wide; the cell chain runs on clk too
   // Path levels follow instr_q one clk late, so the cells see them
   // settled before any strobe of the next data-register pass
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tdo_q         <= 1'b0;
         tdo_oe_n_q    <= 1'b1;
         bsr_capture_q <= 1'b0;
         bsr_shift_q   <= 1'b0;
         bsr_update_q  <= 1'b0;
         bsr_sel_q     <= 1'b0;
         extest_q      <= 1'b0;
         outputs_hiz_q <= 1'b0;
      end else begin
         bsr_sel_q     <= (sel == `TID_SEL_BSR);
         extest_q      <= (instr_q == `TID_OP_EXTEST);
         outputs_hiz_q <= (instr_q == `TID_OP_SAMPLEZ);
         bsr_capture_q <= tck_rise && cap_dr && sel == `TID_SEL_BSR;
         bsr_shift_q   <= tck_rise && sh_dr && sel == `TID_SEL_BSR;
         bsr_update_q  <= tck_fall && state_q == `TID_ST_UPD_DR
                          && sel == `TID_SEL_BSR;
         // Driver on only in the shift states; elsewhere the pin floats
         if (tck_fall) begin
            tdo_oe_n_q <= ~(state_q == `TID_ST_SH_IR || sh_dr);
            if (state_q == `TID_ST_SH_IR)
               tdo_q <= ir_sh_q[0];
            else if (sel == `TID_SEL_IDR)
               tdo_q <= id_sh_q[0];
            else if (sel == `TID_SEL_BSR)
               tdo_q <= bsr_s;
            else
               tdo_q <= byp_q;
         end
      end
   end
endmodule // tid_decoder

// >>> verif/tid_checker.sv
// Purpose: port checks for the test-port instruction decoder
// Assumes: tck slow against clk; path levels lag instr_q by one clk
// Notes:   bound onto every tid_decoder
`timescale 1ns/1ps
module tid_checker (
   input logic       clk,
   input logic       rstn,
   input logic       tck,
   input logic       tdo_q,
   input logic       tdo_oe_n_q,
   input logic       bsr_capture_q,
   input logic       bsr_shift_q,
   input logic       bsr_update_q,
   input logic       bsr_sel_q,
   input logic       extest_q,
   input logic       outputs_hiz_q,
   input logic [2:0] instr_q
);
   // ========
   // Decode is judged only once instr_q has held two clks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   sequence s_settled;
      $stable(instr_q) [*2];
   endsequence
   a_sel_decode: assert property (s_settled |-> bsr_sel_q == (instr_q inside {3'h0, 3'h2, 3'h4}))
      else $error("boundary select wrong");
   a_hiz_decode: assert property (s_settled |-> outputs_hiz_q == (instr_q == 3'h2))
      else $error("float level wrong");
   a_extest_decode: assert property (s_settled |-> extest_q == (instr_q == 3'h0))
      else $error("extest level wrong");
   a_hiz_implies_bsr: assert property (outputs_hiz_q |-> bsr_sel_q && !extest_q)
      else $error("float without boundary path");
   a_instr_quiet: assert property ($changed(instr_q) |-> tdo_oe_n_q)
      else $error("instruction moved while shifting");
   a_tdo_after_fall: assert property ($changed(tdo_q) |-> !$past(tck, 3))
      else $error("tdo moved away from falling tck");
   a_capture_pulse: assert property (bsr_capture_q |-> bsr_sel_q ##1 !bsr_capture_q)
      else $error("capture strobe wrong");
   a_update_pulse: assert property (bsr_update_q |-> bsr_sel_q ##1 !bsr_update_q)
      else $error("update strobe wrong");
   a_shift_on_bsr: assert property (bsr_shift_q |-> bsr_sel_q)
      else $error("boundary shift without selection");
endmodule // tid_checker
bind tid_decoder tid_checker u_tid_checker (.clk(clk), .rstn(rstn), .tck(tck), .tdo_q(tdo_q),
   .tdo_oe_n_q(tdo_oe_n_q), .bsr_capture_q(bsr_capture_q), .bsr_shift_q(bsr_shift_q),
   .bsr_update_q(bsr_update_q), .bsr_sel_q(bsr_sel_q), .extest_q(extest_q),
   .outputs_hiz_q(outputs_hiz_q), .instr_q(instr_q));

// >>> verif/tid_ctrl_model.sv
// Purpose: far-side test controller walking the tms states
// Assumes: tck low between frames, 64 ns period
// Notes:   tdo taken at each rising tck
`timescale 1ns/1ps
module tid_ctrl_model (
   input  wire  clk,
   input  wire  tdo,
   output logic tck,
   output logic tms,
   output logic tdi
);
   // ========
   // Parked: clock still, tms high
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
   end
   // One tck period, tms and tdi held across the rise
   task step(input logic m, input logic b, output logic q);
      tms = m;
      tdi = b;
      repeat (8) @(negedge clk);
      tck = 1'b1;
      q = tdo;
      repeat (8) @(negedge clk);
      tck = 1'b0;
   endtask
   // Walk n tms bits, lsb first
   task walk(input logic [7:0] ms, input int n);
      logic q;
      for (int i = 0; i < n; i++)
         step(ms[i], 1'b0, q);
   endtask
   // Shift n bits lsb first, leaving on the last one
   task shift(input logic [31:0] din, input int n, output logic [31:0] dout);
      logic q;
      dout = '0;
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], q);
         dout[i] = q;
      end
   endtask
   task shift_ir(input logic [2:0] code, output logic [2:0] cap);
      logic [31:0] w;
      walk(8'h03, 4);               // Idle to Shift-IR
      shift({29'h0, code}, 3, w);
      cap = w[2:0];
   endtask
   task update;
      walk(8'h01, 2);   // Update, then Idle
   endtask
   task read_dr(input logic [31:0] din, input int n, output logic [31:0] dout);
      walk(8'h01, 3);   // Select, Capture, Shift-DR
      shift(din, n, dout);
      update;
   endtask
   task tlr;
      walk(8'h1f, 6);   // Five ones reach reset from anywhere
   endtask
endmodule // tid_ctrl_model

// >>> verif/test_tid_decoder.sv
// Purpose: self-checking bench for the test-port instruction decoder
// Assumes: controller model drives tck, tms, tdi
// Notes:   boundary chain stands outside, its serial out held high
`timescale 1ns/1ps
`include "tid_defs.vh"
module test_tid_decoder;
   localparam ID = `TID_IDCODE_VAL;
   logic        clk, rstn, trst_n, tck, tms, tdi, tdo_q, tdo_oe_n_q;
   logic        bsr_capture_q, bsr_shift_q, bsr_update_q, bsr_sel_q, extest_q, outputs_hiz_q;
   logic [2:0]  instr_q, cap;
   logic [31:0] d;
   int          bad_count, compares, cycles;
   logic [23:0] strobe_cnt, strobe_base;   // Pulse counts: capture, shift, update
   wire         tdo_pin = tdo_oe_n_q ? ~tdo_q : tdo_q;   // Released pin shows no stale level
   // ========
   tid_decoder #(.ID_VALUE(ID)) u_tid_decoder (.clk(clk), .rstn(rstn), .tck(tck), .tms(tms),
      .tdi(tdi), .trst_n(trst_n), .bsr_tdo(1'b1), .tdo_q(tdo_q), .tdo_oe_n_q(tdo_oe_n_q),
      .bsr_capture_q(bsr_capture_q), .bsr_shift_q(bsr_shift_q), .bsr_update_q(bsr_update_q),
      .bsr_sel_q(bsr_sel_q), .extest_q(extest_q), .outputs_hiz_q(outputs_hiz_q),
      .instr_q(instr_q));
   tid_ctrl_model u_tid_ctrl_model (.clk(clk), .tdo(tdo_pin), .tck(tck), .tms(tms), .tdi(tdi));
   task check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task summarize;
      $display("mismatches %0d of %0d compares", bad_count, compares);
      if (bad_count == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // ========
   task t_idcode;
      u_tid_ctrl_model.read_dr(32'h0, 32, d);
      check(d, ID);
   endtask
   // Every code: capture pattern, late take-over, path levels, strobe counts, first two bits out
   task t_codes;
      for (int c = 0; c < 8; c++) begin
         u_tid_ctrl_model.shift_ir(c[2:0], cap);
         check(cap, 3'h1);
         check(instr_q, c == 0 ? 1 : c - 1);
         u_tid_ctrl_model.update;
         check(instr_q, c);
         check({extest_q, outputs_hiz_q, bsr_sel_q},
               {c == 0, c == 2, c == 0 || c == 2 || c == 4});
         strobe_base = strobe_cnt;
         u_tid_ctrl_model.read_dr(32'h1, 2, d);
         check(strobe_cnt - strobe_base, (c == 0 || c == 2 || c == 4) ? 24'h01_02_01 : 24'h0);
         check(d, (c == 0 || c == 2 || c == 4) ? 2'b11 : c == 1 ? ID[1:0] : 2'b10);
         check(instr_q, c);
      end
   endtask
   // Both ways back to the identification instruction
   task t_resets;
      u_tid_ctrl_model.tlr;
      check(instr_q, `TID_OP_IDCODE);
      u_tid_ctrl_model.shift_ir(3'h7, cap);
      u_tid_ctrl_model.update;
      trst_n = 1'b0;
      repeat (4) @(negedge clk);
      check(instr_q, `TID_OP_IDCODE);
      trst_n = 1'b1;
   endtask
   // ========
   always #2 clk = ~clk;
   // Boundary strobe pulses, one byte field each
   always @(posedge clk) begin
      strobe_cnt <= !rstn ? 24'h0 : strobe_cnt
                    + {7'h0, bsr_capture_q, 7'h0, bsr_shift_q, 7'h0, bsr_update_q};
   end
   // Hang guard, about four times the expected run
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 12000) begin
         bad_count++;
         summarize;
      end
   end
   initial begin
      clk = 1'b0;
      rstn = 1'b0;
      trst_n = 1'b1;
      repeat (5) @(negedge clk);
      rstn = 1'b1;
      repeat (4) @(negedge clk);
      check(instr_q, `TID_OP_IDCODE);
      u_tid_ctrl_model.tlr;
      t_idcode;
      t_codes;
      t_resets;
      summarize;
   end
endmodule // test_tid_decoder
